// [dv/tcs_adc_model.sv]
/*
  converter front end model: presents a code while a conversion runs.
  assumes the sequencer samples only late in each slot.
*/
`timescale 1ns/1ps
module tcs_adc_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        conv_active,
  input  wire logic [15:0] level,
  output logic      [15:0] sample_data
);
  logic [3:0]  wait_r;
  logic [3:0]  wait_nxt;
  logic [15:0] out_nxt;

  // settle a few cycles after start; outside conversions the code churns
  always_comb begin
    wait_nxt = (!conv_active) ? 4'h0 : ((wait_r < 4'h4) ? wait_r + 4'h1 : wait_r);
    out_nxt  = (conv_active && wait_r == 4'h4) ? level : ~sample_data;
    if (rst) begin
      wait_nxt = 4'h0;
      out_nxt  = 16'h5a5a;
    end
  end
  always_ff @(posedge clock) begin
    wait_r      <= wait_nxt;
    sample_data <= out_nxt;
  end
endmodule  // tcs_adc_model

// [dv/tcs_props.sv]
/*
  port checker for the conversion sequencer: bus answers, power-up quiet
  time, boot values and abort. assumes the top module's port names.
*/
`timescale 1ns/1ps
module tcs_props (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        conv_active,
  input wire logic        event_pin
);
  logic [5:0] since_rst_r;
  logic [5:0] since_rst_nxt;

  // cycles since reset release, saturating
  always_comb begin
    since_rst_nxt = (since_rst_r == 6'h3f) ? since_rst_r : since_rst_r + 6'h01;
    if (rst) since_rst_nxt = 6'h00;
  end
  always_ff @(posedge clock) begin
    since_rst_r <= since_rst_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_rd(logic [7:0] a);
    hsel && htrans[1] && hready && !hwrite && haddr == {24'h0, a};
  endsequence
  sequence s_cfg_wr;
    hsel && htrans[1] && hready && hwrite && haddr == 32'h4;
  endsequence

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  property p_upper_zero;
    hrdata[31:16] == 16'h0;
  endproperty
  property p_idle_data;
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0;
  endproperty
  property p_unmapped;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h0c |=> hrdata == 32'h0;
  endproperty
  property p_powerup_quiet;
    since_rst_r < 6'h10 |-> !conv_active;
  endproperty
  property p_reset_outs;
    $fell(rst) |-> !conv_active && event_pin && hrdata == 32'h0;
  endproperty
  property p_result_boot;
    (since_rst_r < 6'h10) ##0 s_rd(8'h00) |=> hrdata == 32'h8000;
  endproperty
  property p_boot_busy;
    (since_rst_r < 6'h10) ##0 s_rd(8'h04) |=> hrdata[12];
  endproperty
  property p_abort;
    s_cfg_wr ##1 (hwdata[9:8] == 2'h1) |-> ##[1:2] !conv_active;
  endproperty

  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
  a_idle_data: assert property (p_idle_data) else $error("read data without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_powerup_quiet: assert property (p_powerup_quiet) else $error("conversion during power-up");
  a_reset_outs: assert property (p_reset_outs) else $error("outputs wrong after reset");
  a_result_boot: assert property (p_result_boot) else $error("result not most negative at boot");
  a_boot_busy: assert property (p_boot_busy) else $error("busy not shown during power-up");
  a_abort: assert property (p_abort) else $error("power-down write did not stop conversion");
endmodule  // tcs_props

bind tcs_top tcs_props u_props (
  .clock       (clock),
  .rst         (rst),
  .hsel        (hsel),
  .haddr       (haddr),
  .htrans      (htrans),
  .hwrite      (hwrite),
  .hwdata      (hwdata),
  .hready      (hready),
  .hrdata      (hrdata),
  .hreadyout   (hreadyout),
  .hresp       (hresp),
  .conv_active (conv_active),
  .event_pin   (event_pin)
);

// [dv/tcs_top_test.sv]
/*
  self-checking bench for the sequencer: ahb-lite register tasks, single
  runs, continuous mode and a second boot. assumes a shortened timebase.
*/
`timescale 1ns/1ps
module tcs_top_test;
  localparam int          TK   = 10;
  localparam int          SLOT = 31 * TK;
  localparam logic [15:0] SMP [5] = '{16'h0200, 16'hff00, 16'h0200, 16'h0080, 16'hff00};
  localparam logic [1:0]  AVG [5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
  localparam logic        CMP [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
  localparam logic [1:0]  FLG [5] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h0};
  logic        clock = 1'h0;
  logic        rst, hsel, hwrite, hreadyout, hresp, conv_active, event_pin;
  logic        nv_comp, nv_pol, nv_pinf;
  logic [1:0]  htrans, nv_mode, nv_avg;
  logic [2:0]  hsize, nv_conv;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] sample_data, level, nv_high, nv_low;
  int          n_errors, num_checks, cnt, slots;

  always #2 clock = ~clock;

  tcs_top #(.TICK_CYCLES(TK)) dut_u (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_data(sample_data), .nv_operating_state(nv_mode), .nv_sample_count(nv_avg),
    .nv_cycle_time(nv_conv), .nv_comparator_style(nv_comp), .nv_pin_polarity(nv_pol),
    .nv_pin_shows_fresh_flag(nv_pinf), .nv_high_limit(nv_high), .nv_low_limit(nv_low),
    .conv_active(conv_active), .event_pin(event_pin));
  tcs_adc_model adc_u (.clock(clock), .rst(rst), .conv_active(conv_active), .level(level),
    .sample_data(sample_data));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and comparison
  task automatic tally_and_finish;
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one ahb-lite single transfer, held until hready is seen high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    rd = hrdata;
    if (n >= 50) check(32'h0, 32'h1);
    if (n >= 50) tally_and_finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'h0, 32'h0);
    check(rd, exp);
  endtask
  // bounded wait for conv_active (sel 0) or event_pin (sel 1) to reach lvl
  task automatic wait_pin(input logic sel, input logic lvl, input int lim);
    cnt = 0;
    while (((sel ? event_pin : conv_active) !== lvl) && cnt < lim) begin
      @(posedge clock);
      cnt++;
    end
    if (cnt >= lim) check(32'h0, 32'h1);
    if (cnt >= lim) tally_and_finish;
  endtask
  function automatic logic [31:0] cfg(logic [1:0] m, logic [1:0] a, logic [2:0] c, logic f, logic t, logic p);
    cfg = {22'h0, m, c, a, f, t, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, hsize, level} = '0;
    {nv_mode, nv_avg, nv_conv, nv_comp, nv_pol, nv_pinf} = {2'h0, 2'h1, 3'h4, 3'h0};
    {nv_high, nv_low, rst, n_errors, num_checks} = {16'h6000, 16'h8000, 1'h1, 64'h0};
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    rd_chk(8'h00, 32'h8000);
    rd_chk(8'h04, 32'h1088);
    bus(8'h08, 1'h1, 32'h1234);
    rd_chk(8'h08, 32'h6000);
    wait_pin(1'h0, 1'h1, 100);
    rd_chk(8'h04, 32'h0088);
    bus(8'h04, 1'h1, cfg(2'h1, 2'h1, 3'h4, 1'h0, 1'h0, 1'h0));
    @(posedge clock);
    check({31'h0, conv_active}, 32'h0);
    rd_chk(8'h00, 32'h8000);
    rd_chk(8'h10, 32'h0);
    bus(8'h08, 1'h1, 32'h0100);
    bus(8'h0c, 1'h1, 32'h0000);
    // single runs: averaging, duration, limit styles
    for (int i = 0; i < 5; i++) begin
      level <= SMP[i];
      slots = (AVG[i] != 2'h0) ? 8 : 1;
      bus(8'h04, 1'h1, cfg(2'h3, AVG[i], 3'h7, 1'h0, CMP[i], 1'h0));
      wait_pin(1'h0, 1'h1, 20);
      wait_pin(1'h0, 1'h0, 3000);
      check({31'h0, cnt >= slots * SLOT - TK - 2 && cnt <= slots * SLOT + 2}, 32'h1);
      @(posedge clock);
      check({31'h0, event_pin}, {31'h0, FLG[i] == 2'h0});
      rd_chk(8'h04, {16'h0, FLG[i], 14'h2000} | cfg(2'h1, AVG[i], 3'h7, 1'h0, CMP[i], 1'h0));
      rd_chk(8'h00, {16'h0, SMP[i]});
      rd_chk(8'h04, {16'h0, CMP[i] ? FLG[i] : 2'h0, 14'h0} | cfg(2'h1, AVG[i], 3'h7, 1'h0, CMP[i], 1'h0));
    end
    // continuous, event pin showing the fresh flag
    level <= 16'h0011;
    bus(8'h04, 1'h1, cfg(2'h0, 2'h0, 3'h0, 1'h1, 1'h0, 1'h0));
    wait_pin(1'h1, 1'h0, 400);
    rd_chk(8'h00, 32'h0011);
    repeat (3) @(posedge clock);
    check({31'h0, event_pin}, 32'h1);
    level <= 16'h0022;
    wait_pin(1'h1, 1'h0, 400);
    rd_chk(8'h00, 32'h0022);
    // standby length follows the cycle time
    bus(8'h04, 1'h1, cfg(2'h2, 2'h0, 3'h1, 1'h0, 1'h0, 1'h0));
    repeat (2) begin
      wait_pin(1'h0, 1'h0, 400);
      wait_pin(1'h0, 1'h1, 3000);
    end
    check({31'h0, cnt >= 250 * TK - SLOT - 15 && cnt <= 250 * TK - SLOT + 15}, 32'h1);
    // second boot with stored single-run setting
    {nv_mode, nv_avg, nv_conv, nv_comp, nv_pol, nv_pinf} <= {2'h3, 2'h0, 3'h2, 3'h7};
    {nv_high, nv_low, rst} <= {16'h0200, 16'h0100, 1'h1};
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    repeat (60) @(posedge clock);
    check({31'h0, conv_active}, 32'h0);
    check({31'h0, event_pin}, 32'h0);
    rd_chk(8'h04, cfg(2'h1, 2'h0, 3'h2, 1'h1, 1'h1, 1'h1));
    rd_chk(8'h08, 32'h0200);
    tally_and_finish;
  end
endmodule  // tcs_top_test

// [hw/tcs_top.sv]
/*
  conversion sequencer of a digital temperature sensor with an ahb-lite
  register slave. assumes synchronous inputs, a 250 mhz clock, and the
  stored power-up settings held steady on the nv_* inputs.
*/
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
// Summary of operation
// - wait 1.5 ms before any conversion
// - result reads 8000 hex before first conversion
// - averaging 01: eight samples, publish average
// - active time 15.5 ms per sample
// - factory defaults: eight samples, one second cycle
// - averaging in continuous and single-run states
// - result is 16-bit two's complement
// - limits share the result encoding
// - modes 00/10 convert continuously, update result
// - fresh flag sets on completion, clears on result or config reads
// - event pin may show fresh flag
// - continuous cycle: active then standby period
// - writing 01 aborts and powers down
// - writing 11 runs once then powers down
// - single run has no standby period
// - single run end sets fresh and limit flags
// - stored single-run setting starts powered down
// - stored setting may start powered down
// - compare limits at end of every conversion
// - alert style: sticky flags, cleared by config read
// - threshold style: hysteresis, reads do not clear
// - ignore limit/config writes during power-up
`timescale 1ns/1ps
module tcs_top #(
  parameter int TICK_CYCLES = tcs_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] sample_data,
  input  wire logic [1:0]  nv_operating_state,
  input  wire logic [1:0]  nv_sample_count,
  input  wire logic [2:0]  nv_cycle_time,
  input  wire logic        nv_comparator_style,
  input  wire logic        nv_pin_polarity,
  input  wire logic        nv_pin_shows_fresh_flag,
  input  wire logic [15:0] nv_high_limit,
  input  wire logic [15:0] nv_low_limit,
  output logic             conv_active,
  output logic             event_pin
);
  ////////////////////////////////////////////////////////////////////////////
  // timebase divider: one-cycle tick every 0.5 ms
  logic [31:0] div_r, div_nxt;
  logic        tick_r, tick_nxt;

  always_comb begin
    if (div_r == 32'(TICK_CYCLES - 1)) begin
      div_nxt  = 32'h0;
      tick_nxt = 1'b1;
    end else begin
      div_nxt  = div_r + 32'h1;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations shared by the groups below
  tcs_pkg::tcs_state_t state_r, state_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [15:0] ccnt_r, ccnt_nxt;
  logic [2:0]  sidx_r, sidx_nxt;
  logic [18:0] acc_r, acc_nxt;
  logic [15:0] result_r, result_nxt;
  logic        fresh_r, fresh_nxt;
  logic        over_r, over_nxt;
  logic        under_r, under_nxt;
  logic        event_r, event_nxt;
  logic        act_r, act_nxt;
  logic        pol_r, pol_nxt;
  logic        comp_r, comp_nxt;
  logic        pinf_r, pinf_nxt;
  logic [1:0]  avg_r, avg_nxt;
  logic [2:0]  conv_r, conv_nxt;
  logic [1:0]  mode_r, mode_nxt;
  logic [15:0] high_r, high_nxt;
  logic [15:0] low_r, low_nxt;
  logic        ph_wr_r, ph_wr_nxt;
  logic [7:0]  ph_addr_r, ph_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        busy;
  logic        pu_done;
  logic        single_done;
  logic        addr_ok;
  logic        rd_cfg;
  logic        rd_res;
  logic        wr_cfg;
  logic [1:0]  wr_mode;
  logic [31:0] cfg_word;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  assign busy    = (state_r == tcs_pkg::ST_POWERUP);
  assign addr_ok = hsel & htrans[1] & hready & (haddr[31:8] == 24'h0);
  assign rd_cfg  = addr_ok & ~hwrite & (haddr[7:0] == tcs_pkg::ADDR_CONFIG);
  assign rd_res  = addr_ok & ~hwrite & (haddr[7:0] == tcs_pkg::ADDR_RESULT);
  assign wr_cfg  = ph_wr_r & ~busy & (ph_addr_r == tcs_pkg::ADDR_CONFIG);
  assign wr_mode = hwdata[tcs_pkg::CFG_MODE +: 2];

  // configuration readback word
  always_comb begin
    cfg_word                          = 32'h0;
    cfg_word[tcs_pkg::CFG_POL]        = pol_r;
    cfg_word[tcs_pkg::CFG_COMP]       = comp_r;
    cfg_word[tcs_pkg::CFG_PINF]       = pinf_r;
    cfg_word[tcs_pkg::CFG_AVG +: 2]   = avg_r;
    cfg_word[tcs_pkg::CFG_CONV +: 3]  = conv_r;
    cfg_word[tcs_pkg::CFG_MODE +: 2]  = mode_r;
    cfg_word[tcs_pkg::CFG_BUSY]       = busy;
    cfg_word[tcs_pkg::CFG_FRESH]      = fresh_r;
    cfg_word[tcs_pkg::CFG_UNDER]      = under_r & ~comp_r;
    cfg_word[tcs_pkg::CFG_OVER]       = over_r;
  end

  // address phase capture and read data; reads still answered while busy
  always_comb begin
    ph_wr_nxt   = addr_ok & hwrite;
    ph_addr_nxt = haddr[7:0];
    hrdata_nxt  = 32'h0;
    if (addr_ok & ~hwrite) begin
      case (haddr[7:0])
        tcs_pkg::ADDR_RESULT: hrdata_nxt = {16'h0, result_r};
        tcs_pkg::ADDR_CONFIG: hrdata_nxt = cfg_word;
        tcs_pkg::ADDR_HIGH:   hrdata_nxt = {16'h0, high_r};
        tcs_pkg::ADDR_LOW:    hrdata_nxt = {16'h0, low_r};
        default:              hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h0;
      hrdata_r  <= 32'h0;
    end else begin
      ph_wr_r   <= ph_wr_nxt;
      ph_addr_r <= ph_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;

  // ready and response are constant flops so outputs stay registered
  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and limit registers
  always_comb begin
    pol_nxt  = pol_r;
    comp_nxt = comp_r;
    pinf_nxt = pinf_r;
    avg_nxt  = avg_r;
    conv_nxt = conv_r;
    mode_nxt = mode_r;
    high_nxt = high_r;
    low_nxt  = low_r;
    if (pu_done) begin
      pol_nxt  = nv_pin_polarity;
      comp_nxt = nv_comparator_style;
      pinf_nxt = nv_pin_shows_fresh_flag;
      avg_nxt  = nv_sample_count;
      conv_nxt = nv_cycle_time;
      high_nxt = nv_high_limit;
      low_nxt  = nv_low_limit;
      // a stored single-run setting starts powered down
      mode_nxt = (nv_operating_state == tcs_pkg::MODE_SINGLE) ? tcs_pkg::MODE_DOWN : nv_operating_state;
    end else begin
      if (single_done) begin
        mode_nxt = tcs_pkg::MODE_DOWN;
      end
      if (wr_cfg) begin
        pol_nxt  = hwdata[tcs_pkg::CFG_POL];
        comp_nxt = hwdata[tcs_pkg::CFG_COMP];
        pinf_nxt = hwdata[tcs_pkg::CFG_PINF];
        avg_nxt  = hwdata[tcs_pkg::CFG_AVG +: 2];
        conv_nxt = hwdata[tcs_pkg::CFG_CONV +: 3];
        mode_nxt = wr_mode;
      end
      // limits take the same raw 16-bit code as the result
      if (ph_wr_r & ~busy & (ph_addr_r == tcs_pkg::ADDR_HIGH)) begin
        high_nxt = hwdata[15:0];
      end
      if (ph_wr_r & ~busy & (ph_addr_r == tcs_pkg::ADDR_LOW)) begin
        low_nxt = hwdata[15:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pol_r  <= 1'b0;
      comp_r <= 1'b0;
      pinf_r <= 1'b0;
      avg_r  <= tcs_pkg::FACT_AVG;
      conv_r <= tcs_pkg::FACT_CONV;
      mode_r <= tcs_pkg::FACT_MODE;
      high_r <= tcs_pkg::FACT_HIGH;
      low_r  <= tcs_pkg::FACT_LOW;
    end else begin
      pol_r  <= pol_nxt;
      comp_r <= comp_nxt;
      pinf_r <= pinf_nxt;
      avg_r  <= avg_nxt;
      conv_r <= conv_nxt;
      mode_r <= mode_nxt;
      high_r <= high_nxt;
      low_r  <= low_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer, result, flags and event pin
  logic [18:0] acc_sum;
  logic [15:0] avg_val;
  logic        last_sample;
  logic        cmp_gt;
  logic        cmp_lt;
  logic        pin_active;

  assign acc_sum     = acc_r + {{3{sample_data[15]}}, sample_data};
  assign avg_val     = (avg_r == 2'h0) ? sample_data : acc_sum[tcs_pkg::AVG_SHIFT +: 16];
  assign last_sample = (avg_r == 2'h0) | (sidx_r == tcs_pkg::AVG_LAST);
  assign cmp_gt      = $signed(avg_val) > $signed(high_r);
  assign cmp_lt      = $signed(avg_val) < $signed(low_r);
  assign pu_done     = busy & tick_r & (tcnt_r == tcs_pkg::POWERUP_TICKS - 16'h1);

  always_comb begin
    state_nxt   = state_r;
    tcnt_nxt    = tcnt_r;
    ccnt_nxt    = ccnt_r;
    sidx_nxt    = sidx_r;
    acc_nxt     = acc_r;
    result_nxt  = result_r;
    single_done = 1'b0;
    // read-clears first, so a completion in the same cycle wins
    fresh_nxt   = fresh_r & ~(rd_cfg | rd_res);
    over_nxt    = over_r & ~(rd_cfg & ~comp_r);
    under_nxt   = under_r & ~(rd_cfg & ~comp_r);
    case (state_r)
      tcs_pkg::ST_POWERUP: begin
        if (tick_r) begin
          tcnt_nxt = tcnt_r + 16'h1;
        end
        if (pu_done) begin
          tcnt_nxt = 16'h0;
          ccnt_nxt = 16'h0;
          if ((nv_operating_state == tcs_pkg::MODE_DOWN) | (nv_operating_state == tcs_pkg::MODE_SINGLE)) begin
            state_nxt = tcs_pkg::ST_DOWN;
          end else begin
            state_nxt = tcs_pkg::ST_ACTIVE;
          end
        end
      end
      tcs_pkg::ST_DOWN: begin
        if (wr_cfg & (wr_mode != tcs_pkg::MODE_DOWN)) begin
          state_nxt = tcs_pkg::ST_ACTIVE;
          tcnt_nxt  = 16'h0;
          ccnt_nxt  = 16'h0;
          sidx_nxt  = 3'h0;
          acc_nxt   = 19'h0;
        end
      end
      tcs_pkg::ST_ACTIVE: begin
        if (wr_cfg & (wr_mode == tcs_pkg::MODE_DOWN)) begin
          // abort drops partial samples, result keeps last value
          state_nxt = tcs_pkg::ST_DOWN;
          sidx_nxt  = 3'h0;
          acc_nxt   = 19'h0;
        end else if (tick_r) begin
          tcnt_nxt = tcnt_r + 16'h1;
          ccnt_nxt = ccnt_r + 16'h1;
          if (tcnt_r == tcs_pkg::CONV_TICKS - 16'h1) begin
            tcnt_nxt = 16'h0;
            if (last_sample) begin
              result_nxt = avg_val;
              fresh_nxt  = 1'b1;
              sidx_nxt   = 3'h0;
              acc_nxt    = 19'h0;
              if (comp_r) begin
                // threshold style: high limit sets, low limit releases
                under_nxt = 1'b0;
                if (cmp_gt) begin
                  over_nxt = 1'b1;
                end else if (cmp_lt) begin
                  over_nxt = 1'b0;
                end
              end else begin
                over_nxt  = over_nxt | cmp_gt;
                under_nxt = under_nxt | cmp_lt;
              end
              if (mode_r == tcs_pkg::MODE_SINGLE) begin
                state_nxt   = tcs_pkg::ST_DOWN;
                single_done = 1'b1;
              end else if (ccnt_r + 16'h1 >= tcs_pkg::period_ticks(conv_r)) begin
                ccnt_nxt = 16'h0;
              end else begin
                state_nxt = tcs_pkg::ST_STANDBY;
              end
            end else begin
              sidx_nxt = sidx_r + 3'h1;
              acc_nxt  = acc_sum;
            end
          end
        end
      end
      tcs_pkg::ST_STANDBY: begin
        if (wr_cfg & (wr_mode == tcs_pkg::MODE_DOWN)) begin
          state_nxt = tcs_pkg::ST_DOWN;
        end else if (wr_cfg & (wr_mode == tcs_pkg::MODE_SINGLE)) begin
          state_nxt = tcs_pkg::ST_ACTIVE;
          tcnt_nxt  = 16'h0;
          ccnt_nxt  = 16'h0;
        end else if (tick_r) begin
          ccnt_nxt = ccnt_r + 16'h1;
          if (ccnt_r + 16'h1 >= tcs_pkg::period_ticks(conv_r)) begin
            state_nxt = tcs_pkg::ST_ACTIVE;
            ccnt_nxt  = 16'h0;
          end
        end
      end
      default: begin
        state_nxt = tcs_pkg::ST_POWERUP;
        tcnt_nxt  = 16'h0;
      end
    endcase
    act_nxt    = (state_nxt == tcs_pkg::ST_ACTIVE);
    pin_active = pinf_r ? fresh_r : (over_r | (under_r & ~comp_r));
    event_nxt  = pol_r ? pin_active : ~pin_active;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r  <= tcs_pkg::ST_POWERUP;
      tcnt_r   <= 16'h0;
      ccnt_r   <= 16'h0;
      sidx_r   <= 3'h0;
      acc_r    <= 19'h0;
      result_r <= tcs_pkg::RESULT_RESET;
      fresh_r  <= 1'b0;
      over_r   <= 1'b0;
      under_r  <= 1'b0;
      act_r    <= 1'b0;
      event_r  <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      tcnt_r   <= tcnt_nxt;
      ccnt_r   <= ccnt_nxt;
      sidx_r   <= sidx_nxt;
      acc_r    <= acc_nxt;
      result_r <= result_nxt;
      fresh_r  <= fresh_nxt;
      over_r   <= over_nxt;
      under_r  <= under_nxt;
      act_r    <= act_nxt;
      event_r  <= event_nxt;
    end
  end

  assign conv_active = act_r;
  assign event_pin   = event_r;
endmodule // tcs_top

// [shared/tcs_pkg.sv]
/*
  constants, field layout, timing and state encoding for the temperature
  conversion sequencer. assumes a 250 mhz clock and a 0.5 ms timebase tick.
*/
package tcs_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses on the ahb-lite window
  localparam logic [7:0]  ADDR_RESULT = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG = 8'h04;
  localparam logic [7:0]  ADDR_HIGH   = 8'h08;
  localparam logic [7:0]  ADDR_LOW    = 8'h0c;

  // configuration register field positions
  localparam int          CFG_POL     = 0;   // pin_polarity_select
  localparam int          CFG_COMP    = 1;   // comparator_style_select
  localparam int          CFG_PINF    = 2;   // pin_shows_fresh_flag
  localparam int          CFG_AVG     = 3;   // sample_count_select, 2 bits
  localparam int          CFG_CONV    = 5;   // cycle_time_select, 3 bits
  localparam int          CFG_MODE    = 8;   // operating_state_select, 2 bits
  localparam int          CFG_BUSY    = 12;  // power-up load in progress
  localparam int          CFG_FRESH   = 13;  // fresh-result flag
  localparam int          CFG_UNDER   = 14;  // under-limit flag
  localparam int          CFG_OVER    = 15;  // over-limit flag

  // values after reset
  localparam logic [15:0] RESULT_RESET = 16'h8000;  // most negative code
  localparam logic [1:0]  FACT_MODE    = 2'h0;
  localparam logic [1:0]  FACT_AVG     = 2'h1;      // eight samples
  localparam logic [2:0]  FACT_CONV    = 3'h4;      // one second cycle
  localparam logic [15:0] FACT_HIGH    = 16'h6000;
  localparam logic [15:0] FACT_LOW     = 16'h8000;

  // operating state encodings
  localparam logic [1:0]  MODE_CONT_A  = 2'h0;
  localparam logic [1:0]  MODE_DOWN    = 2'h1;
  localparam logic [1:0]  MODE_CONT_B  = 2'h2;
  localparam logic [1:0]  MODE_SINGLE  = 2'h3;

  // timing: times in their own unit, counts derived
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          TICK_PS       = 500000000;  // 0.5 ms timebase
  localparam int          TICK_CYCLES   = TICK_PS / CLK_PERIOD_PS;
  localparam int          POWERUP_US    = 1500;       // 1.5 ms
  localparam int          CONV_US       = 15500;      // 15.5 ms
  localparam logic [15:0] POWERUP_TICKS = 16'((POWERUP_US * 1000 + TICK_PS / 1000 - 1) / (TICK_PS / 1000));
  localparam logic [15:0] CONV_TICKS    = 16'((CONV_US * 1000 + TICK_PS / 1000 - 1) / (TICK_PS / 1000));
  localparam logic [2:0]  AVG_LAST      = 3'h7;       // index of eighth sample
  localparam int          AVG_SHIFT     = 3;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_POWERUP = 4'b0001,
    ST_DOWN    = 4'b0010,
    ST_ACTIVE  = 4'b0100,
    ST_STANDBY = 4'b1000
  } tcs_state_t;

  // cycle period in 0.5 ms ticks for each cycle_time_select code
  function automatic logic [15:0] period_ticks(input logic [2:0] sel);
    case (sel)
      3'h0:    period_ticks = 16'h001f;  // 15.5 ms
      3'h1:    period_ticks = 16'h00fa;  // 125 ms
      3'h2:    period_ticks = 16'h01f4;  // 250 ms
      3'h3:    period_ticks = 16'h03e8;  // 500 ms
      3'h4:    period_ticks = 16'h07d0;  // 1 s
      3'h5:    period_ticks = 16'h1f40;  // 4 s
      3'h6:    period_ticks = 16'h3e80;  // 8 s
      default: period_ticks = 16'h7d00;  // 16 s
    endcase
  endfunction
endpackage
